/* File: cdct_asic_model.sv */
/*
 * Baseband side model driving the shared transmit bus.
 * Assumes rising-edge capture when dual; words held a whole tx clock period.
 */
`default_nettype none
module cdct_asic_model (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        en,
    input  wire logic        tx_clk,
    input  wire logic        dual,
    input  wire logic        pol,
    input  wire logic [13:0] word_a,
    input  wire logic [13:0] word_b,
    output var  logic [13:0] tx_data,
    output var  logic        tx_mark
);
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_q;
    logic send_b_q;
    // words move on falling edges, clear of capture
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            clk_q    <= 1'b0;
            send_b_q <= 1'b0;
            tx_data  <= 14'h0000;
            tx_mark  <= 1'b0;
        end else begin
            clk_q <= tx_clk;
            if (!en) begin
                send_b_q <= 1'b0;
                tx_data  <= ~tx_data;
            end else if (clk_q && !tx_clk) begin
                // A then B, marker low for A unless swapped
                send_b_q <= dual && !send_b_q;
                tx_data  <= send_b_q ? word_b : word_a;
                tx_mark  <= send_b_q ^ pol;
            end
        end
    end
endmodule
`default_nettype wire

/* File: cdct_clkdiv.v */
/*
 * Square-wave clock generator with a half period in CLK cycles.
 * Assumes HALF is at least one; a new HALF is taken only at a rising edge.
 */
`include "cdct_defines.vh"
`default_nettype none

module cdct_clkdiv (
    input  wire                    CLK,
    input  wire                    RSTN,
    input  wire [`CDCT_CNT_W-1:0]  HALF,
    output wire                    PIN,
    output wire                    RISE,
    output wire                    FALL
);

    reg  [`CDCT_CNT_W-1:0] cnt_q;
    reg  [`CDCT_CNT_W-1:0] half_q;
    reg                    pin_q;
    wire                   last;

    assign last = (cnt_q == half_q - 6'h01);

    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            cnt_q  <= 6'h00;
            half_q <= `CDCT_RX_HALF_SLOW;
            pin_q  <= 1'b0;
        end else if (last) begin
            cnt_q <= 6'h00;
            pin_q <= ~pin_q;
            // Ratio change at period start
            if (!pin_q) begin
                half_q <= (HALF == 6'h00) ? 6'h01 : HALF;
            end
        end else begin
            cnt_q <= cnt_q + 6'h01;
        end
    end

    assign PIN  = pin_q;
    assign RISE = last & ~pin_q;
    assign FALL = last & pin_q;

endmodule

`default_nettype wire

/* File: cdct_defines.vh */
/*
 * Shared constants for the converter clock and data timing block.
 * Assumes CLK runs at eight times the input clock rate.
 */
`ifndef CDCT_DEFINES_VH
`define CDCT_DEFINES_VH

// Clock rates
`define CDCT_CLK_MHZ          250
`define CDCT_IN_CLK_RATIO     8

// Multiplier codes, log2 of the factor
`define CDCT_MULT_1X          2'h0
`define CDCT_MULT_2X          2'h1
`define CDCT_MULT_4X          2'h2

// Divide factor codes, log2 of the divisor
`define CDCT_DIV_1            2'h0
`define CDCT_DIV_2            2'h1
`define CDCT_DIV_4            2'h2

// Half periods in CLK cycles, LOG ones as log2; the sample base is a whole sample period
`define CDCT_IN_HALF_LOG      3'h2
`define CDCT_RX_HALF_FULL     6'h04
`define CDCT_RX_HALF_SLOW     6'h08
`define CDCT_SAMPLE_BASE_LOG  3'h3

// Widths
`define CDCT_CNT_W            6
`define CDCT_RX_W             12
`define CDCT_TX_W             14

// Reset values
`define CDCT_RST_WORD_RX      12'h000
`define CDCT_RST_WORD_TX      14'h0000

`endif

/* File: cdct_sync.v */
/*
 * Two-stage synchroniser for signals arriving from pins.
 * Assumes multi-bit users tolerate one sample of skew between bits.
 */
`default_nettype none

module cdct_sync #(
    parameter W = 1
) (
    input  wire         CLK,
    input  wire         RSTN,
    input  wire [W-1:0] D,
    output wire [W-1:0] Q
);

    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= D;
            sync_q <= meta_q;
        end
    end

    assign Q = sync_q;

endmodule

`default_nettype wire

/* File: cdct_timing.v */
/*
 * Clock derivation, receive output framing and transmit input capture.
 * Assumes CLK is eight times the input clock; faster loop clocks are enables.
 */
//
// Behaviour
// - Strap high at power-up selects the alternative timing mode.
// - Alternative mode receive data rate also follows the multiplier setting.
// - Alternative mode samples at full or half multiplier-loop rate.
// - Receive data launched against rx_output_clock unless retimed.
// - Decimation halves rate; multiplexing puts both channels on bus A.
// - Marker travels with each muxed word; high marks channel A.
// - Receive marker polarity setting inverts marker meaning.
// - rx_output_clock is input clock, or half of it when select low.
// - Clock invert flips rx_output_clock; data uses the opposite edges.
// - Alternative transmit timing ignores the sample halve setting.
// - Transmit data captured on tx_input_clock unless retimed to rx clock.
// - Transmit words latched on rising, falling or both edges.
// - Dual-channel transmit words are demultiplexed into two paths.
// - tx_input_clock equals input clock times multiplier over divide factor, halved in normal mode when sample halve is set.
// - Complex order swap steers interleaved words to the paths.
// - Alternative mode defaults the multiplier to four times.
`include "cdct_defines.vh"
`default_nettype none

module cdct_timing (
    input  wire                    CLK,
    input  wire                    RSTN,
    input  wire                    TIMING_MODE_STRAP,
    input  wire [1:0]              CLOCK_MULTIPLIER_SETTING,
    input  wire                    MULT_SETTING_VALID,
    input  wire                    SAMPLE_CLOCK_HALVE,
    input  wire                    OUT_CLOCK_RATE_SELECT,
    input  wire                    RX_CLOCK_INVERT,
    input  wire                    RX_RETIME_SELECT,
    input  wire                    RX_DECIMATE,
    input  wire                    RX_MUX,
    input  wire                    RX_MARKER_POLARITY,
    input  wire [`CDCT_RX_W-1:0]   ADC_A_DATA,
    input  wire [`CDCT_RX_W-1:0]   ADC_B_DATA,
    input  wire [1:0]              TX_CLOCK_DIVIDE_FACTOR,
    input  wire                    TX_RETIME_SELECT,
    input  wire                    TX_FALLING_EDGE_SELECT,
    input  wire                    TX_DUAL_EDGE_SELECT,
    input  wire                    TX_DUAL_CHANNEL,
    input  wire                    TX_MARKER_POLARITY,
    input  wire                    COMPLEX_ORDER_SWAP,
    input  wire [`CDCT_TX_W-1:0]   TX_DATA,
    input  wire                    TX_CHANNEL_MARKER,
    output wire                    ALT_MODE,
    output wire                    SAMPLE_STROBE,
    output wire                    RX_OUTPUT_CLOCK,
    output wire                    TX_INPUT_CLOCK,
    output wire [`CDCT_RX_W-1:0]   RX_A_OUT,
    output wire [`CDCT_RX_W-1:0]   RX_B_OUT,
    output wire                    RX_CHANNEL_MARKER,
    output wire [`CDCT_TX_W-1:0]   DAC_A_DATA,
    output wire [`CDCT_TX_W-1:0]   DAC_B_DATA,
    output wire                    DAC_VALID
);

    ////////////////////////////////////////////////////////////////////////
    // Functions

    function [`CDCT_CNT_W-1:0] pow2;
        input [2:0] sh;
        begin
            pow2 = 6'h01 << sh;
        end
    endfunction

    function [1:0] clamp_log;
        input [1:0] code;
        begin
            clamp_log = (code == 2'h3) ? 2'h2 : code;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    wire                  strap_s;
    wire [`CDCT_TX_W-1:0] tx_data_s;
    wire                  tx_marker_s;

    cdct_sync #(.W(1)) u_sync_strap (
        .CLK  (CLK),
        .RSTN (RSTN),
        .D    (TIMING_MODE_STRAP),
        .Q    (strap_s)
    );

    // Bus skew limitation: partner holds words over several CLK cycles
    cdct_sync #(.W(`CDCT_TX_W + 1)) u_sync_tx (
        .CLK  (CLK),
        .RSTN (RSTN),
        .D    ({TX_CHANNEL_MARKER, TX_DATA}),
        .Q    ({tx_marker_s, tx_data_s})
    );

    ////////////////////////////////////////////////////////////////////////
    // Mode capture

    reg       mode_taken_q;
    reg       alt_mode_q;
    reg [1:0] settle_q;

    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            settle_q     <= 2'h0;
            mode_taken_q <= 1'b0;
            alt_mode_q   <= 1'b0;
        end else if (!mode_taken_q) begin
            // Wait for synchroniser to fill before trusting the strap
            if (settle_q == 2'h2) begin
                mode_taken_q <= 1'b1;
                alt_mode_q   <= strap_s;
            end else begin
                settle_q <= settle_q + 2'h1;
            end
        end
    end

    assign ALT_MODE = alt_mode_q;

    ////////////////////////////////////////////////////////////////////////
    // Rate derivation

    wire [1:0] mult_log;
    wire [1:0] div_log;
    reg  [2:0] smp_log;
    reg  [2:0] tx_log;
    wire [`CDCT_CNT_W-1:0] rx_half;
    wire [`CDCT_CNT_W-1:0] tx_half;

    // Default four times in alternative mode
    assign mult_log = (alt_mode_q && !MULT_SETTING_VALID) ? `CDCT_MULT_4X :
                      clamp_log(CLOCK_MULTIPLIER_SETTING);
    assign div_log  = clamp_log(TX_CLOCK_DIVIDE_FACTOR);

    always @* begin
        smp_log = `CDCT_SAMPLE_BASE_LOG;
        tx_log  = `CDCT_IN_HALF_LOG;
        if (alt_mode_q) begin
            smp_log = `CDCT_SAMPLE_BASE_LOG - {1'b0, mult_log} + {2'h0, SAMPLE_CLOCK_HALVE};
            tx_log  = `CDCT_IN_HALF_LOG + {1'b0, div_log} - {1'b0, mult_log};
        end else begin
            smp_log = `CDCT_SAMPLE_BASE_LOG + {2'h0, SAMPLE_CLOCK_HALVE};
            tx_log  = `CDCT_IN_HALF_LOG + {1'b0, div_log} - {1'b0, mult_log}
                      + {2'h0, SAMPLE_CLOCK_HALVE};
        end
    end

    // Input clock rate or half of it
    assign rx_half = OUT_CLOCK_RATE_SELECT ? `CDCT_RX_HALF_FULL : `CDCT_RX_HALF_SLOW;
    assign tx_half = pow2(tx_log);

    ////////////////////////////////////////////////////////////////////////
    // Output clocks

    wire rx_clk_int;
    wire rx_rise;
    wire rx_fall;
    wire tx_clk_int;
    wire tx_rise;
    wire tx_fall;

    cdct_clkdiv u_rx_clk (
        .CLK  (CLK),
        .RSTN (RSTN),
        .HALF (rx_half),
        .PIN  (rx_clk_int),
        .RISE (rx_rise),
        .FALL (rx_fall)
    );

    cdct_clkdiv u_tx_clk (
        .CLK  (CLK),
        .RSTN (RSTN),
        .HALF (tx_half),
        .PIN  (tx_clk_int),
        .RISE (tx_rise),
        .FALL (tx_fall)
    );

    reg rx_pin_q;
    reg tx_pin_q;

    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rx_pin_q <= 1'b0;
            tx_pin_q <= 1'b0;
        end else begin
            rx_pin_q <= rx_clk_int ^ RX_CLOCK_INVERT;
            tx_pin_q <= tx_clk_int;
        end
    end

    assign RX_OUTPUT_CLOCK = rx_pin_q;
    assign TX_INPUT_CLOCK  = tx_pin_q;

    ////////////////////////////////////////////////////////////////////////
    // Sample strobe and decimation

    reg [`CDCT_CNT_W-1:0] smp_cnt_q;
    reg                   smp_q;
    reg                   dec_ph_q;
    wire [`CDCT_CNT_W-1:0] smp_period;

    assign smp_period = pow2(smp_log);

    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            smp_cnt_q <= 6'h00;
            smp_q     <= 1'b0;
            dec_ph_q  <= 1'b0;
        end else begin
            smp_q <= 1'b0;
            if (smp_cnt_q >= smp_period - 6'h01) begin
                smp_cnt_q <= 6'h00;
                smp_q     <= 1'b1;
            end else begin
                smp_cnt_q <= smp_cnt_q + 6'h01;
            end
            if (smp_q) begin
                dec_ph_q <= ~dec_ph_q;
            end
        end
    end

    assign SAMPLE_STROBE = smp_q;

    ////////////////////////////////////////////////////////////////////////
    // Receive output framing

    reg [`CDCT_RX_W-1:0] hold_a_q;
    reg [`CDCT_RX_W-1:0] hold_b_q;
    reg                  pair_rdy_q;
    reg                  mux_ph_q;
    reg [`CDCT_RX_W-1:0] out_a_q;
    reg [`CDCT_RX_W-1:0] out_b_q;
    reg                  chan_a_q;
    wire                 keep;
    wire                 launch;

    assign keep   = smp_q && (!RX_DECIMATE || dec_ph_q);
    // Launch edge opposite the capture edge
    assign launch = RX_RETIME_SELECT ? smp_q : (RX_CLOCK_INVERT ? rx_rise : rx_fall);

    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            hold_a_q   <= `CDCT_RST_WORD_RX;
            hold_b_q   <= `CDCT_RST_WORD_RX;
            pair_rdy_q <= 1'b0;
            mux_ph_q   <= 1'b0;
            out_a_q    <= `CDCT_RST_WORD_RX;
            out_b_q    <= `CDCT_RST_WORD_RX;
            chan_a_q   <= 1'b0;
        end else begin
            if (keep) begin
                hold_a_q   <= ADC_A_DATA;
                hold_b_q   <= ADC_B_DATA;
            end
            if (launch) begin
                if (RX_MUX) begin
                    if (mux_ph_q) begin
                        out_a_q  <= hold_b_q;
                        chan_a_q <= 1'b0;
                        mux_ph_q <= 1'b0;
                    end else if (pair_rdy_q || keep) begin
                        out_a_q  <= keep ? ADC_A_DATA : hold_a_q;
                        chan_a_q <= 1'b1;
                        mux_ph_q <= 1'b1;
                    end
                    out_b_q <= `CDCT_RST_WORD_RX;
                end else if (pair_rdy_q || keep) begin
                    out_a_q  <= keep ? ADC_A_DATA : hold_a_q;
                    out_b_q  <= keep ? ADC_B_DATA : hold_b_q;
                    chan_a_q <= 1'b1;
                    mux_ph_q <= 1'b0;
                end
            end
            // Consumption wins over a new pair in the same cycle
            if (keep && !(launch && !mux_ph_q)) begin
                pair_rdy_q <= 1'b1;
            end else if (launch && !mux_ph_q) begin
                pair_rdy_q <= 1'b0;
            end
        end
    end

    assign RX_A_OUT = out_a_q;
    assign RX_B_OUT = out_b_q;
    assign RX_CHANNEL_MARKER = chan_a_q ^ RX_MARKER_POLARITY;

    ////////////////////////////////////////////////////////////////////////
    // Transmit capture

    reg                  cap;
    wire                 tx_base_rise;
    wire                 tx_base_fall;
    wire                 is_b;
    reg [`CDCT_TX_W-1:0] first_q;
    reg [`CDCT_TX_W-1:0] dac_a_q;
    reg [`CDCT_TX_W-1:0] dac_b_q;
    reg                  dac_vld_q;

    assign tx_base_rise = TX_RETIME_SELECT ? rx_rise : tx_rise;
    assign tx_base_fall = TX_RETIME_SELECT ? rx_fall : tx_fall;

    always @* begin
        cap = 1'b0;
        if (TX_DUAL_EDGE_SELECT) begin
            cap = tx_base_rise | tx_base_fall;
        end else if (TX_FALLING_EDGE_SELECT) begin
            cap = tx_base_fall;
        end else begin
            cap = tx_base_rise;
        end
    end

    // Marker low is channel A unless swapped
    assign is_b = tx_marker_s ^ TX_MARKER_POLARITY;

    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            first_q   <= `CDCT_RST_WORD_TX;
            dac_a_q   <= `CDCT_RST_WORD_TX;
            dac_b_q   <= `CDCT_RST_WORD_TX;
            dac_vld_q <= 1'b0;
        end else begin
            dac_vld_q <= 1'b0;
            if (cap) begin
                if (!TX_DUAL_CHANNEL) begin
                    dac_a_q   <= tx_data_s;
                    dac_vld_q <= 1'b1;
                end else if (!is_b) begin
                    first_q <= tx_data_s;
                end else begin
                    dac_a_q   <= COMPLEX_ORDER_SWAP ? tx_data_s : first_q;
                    dac_b_q   <= COMPLEX_ORDER_SWAP ? first_q : tx_data_s;
                    dac_vld_q <= 1'b1;
                end
            end
        end
    end

    assign DAC_A_DATA = dac_a_q;
    assign DAC_B_DATA = dac_b_q;
    assign DAC_VALID  = dac_vld_q;

endmodule

`default_nettype wire

/* File: cdct_timing_monitor.sv */
/*
 * Port checker for cdct_timing.
 * Assumes binding to cdct_timing; judges settings held for 127 cycles, except the mode check, which starts 7 cycles after reset.
 */
`default_nettype none
module cdct_timing_monitor (
    input wire logic        CLK,
    input wire logic        RSTN,
    input wire logic [1:0]  CLOCK_MULTIPLIER_SETTING,
    input wire logic        MULT_SETTING_VALID,
    input wire logic        SAMPLE_CLOCK_HALVE,
    input wire logic        OUT_CLOCK_RATE_SELECT,
    input wire logic        RX_CLOCK_INVERT,
    input wire logic        RX_MUX,
    input wire logic [1:0]  TX_CLOCK_DIVIDE_FACTOR,
    input wire logic        TX_DUAL_CHANNEL,
    input wire logic        ALT_MODE,
    input wire logic        SAMPLE_STROBE,
    input wire logic        RX_OUTPUT_CLOCK,
    input wire logic        TX_INPUT_CLOCK,
    input wire logic [11:0] RX_B_OUT,
    input wire logic [13:0] DAC_B_DATA
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] cfg;
    logic [9:0] cfg_q;
    logic [6:0] age_q;
    logic [3:0] gap_q;
    logic [2:0] run_q;
    logic       steady;
    logic       rx_raw;
    logic       alt4;
    // Inversion is a plain XOR, so undo it to see the divider itself
    assign rx_raw = RX_OUTPUT_CLOCK ^ RX_CLOCK_INVERT;
    assign cfg = {CLOCK_MULTIPLIER_SETTING, MULT_SETTING_VALID, SAMPLE_CLOCK_HALVE, OUT_CLOCK_RATE_SELECT,
                  RX_MUX, TX_CLOCK_DIVIDE_FACTOR, TX_DUAL_CHANNEL, ALT_MODE};
    assign steady = age_q == 7'h7F && cfg == cfg_q;
    assign alt4 = ALT_MODE && (!MULT_SETTING_VALID || CLOCK_MULTIPLIER_SETTING == 2'h2);
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            cfg_q <= 10'h000;
            age_q <= 7'h00;
            gap_q <= 4'h0;
            run_q <= 3'h0;
        end else begin
            cfg_q <= cfg;
            age_q <= (cfg != cfg_q) ? 7'h00 : age_q + {6'h00, age_q != 7'h7F};
            gap_q <= SAMPLE_STROBE ? 4'h0 : gap_q + {3'h0, gap_q != 4'hF};
            run_q <= run_q + {2'h0, run_q != 3'h7};
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    ////////////////////////////////////////
    rx_full_a: assert property (steady && OUT_CLOCK_RATE_SELECT && $rose(rx_raw) |->
        rx_raw[*4] ##1 !rx_raw) else $error("rx clock high phase not 4");
    rx_slow_a: assert property (steady && !OUT_CLOCK_RATE_SELECT && $rose(rx_raw) |->
        rx_raw[*8] ##1 !rx_raw) else $error("rx clock high phase not 8");
    samp_four_a: assert property (steady && !MULT_SETTING_VALID && ALT_MODE && !SAMPLE_CLOCK_HALVE
        && SAMPLE_STROBE |-> $past(SAMPLE_STROBE, 2) && !$past(SAMPLE_STROBE)) else $error("strobe period not 2");
    samp_halve_a: assert property (steady && alt4 && SAMPLE_CLOCK_HALVE && SAMPLE_STROBE |->
        gap_q == 4'h3) else $error("strobe period not 4");
    samp_mult_a: assert property (steady && ALT_MODE && MULT_SETTING_VALID && CLOCK_MULTIPLIER_SETTING == 2'h0
        && !SAMPLE_CLOCK_HALVE && SAMPLE_STROBE |-> gap_q == 4'h7) else $error("strobe period not 8");
    tx_fast_a: assert property (steady && ALT_MODE && !MULT_SETTING_VALID && TX_CLOCK_DIVIDE_FACTOR == 2'h0
        |-> TX_INPUT_CLOCK != $past(TX_INPUT_CLOCK)) else $error("tx clock not toggling each cycle");
    tx_mid_a: assert property (steady && ALT_MODE && MULT_SETTING_VALID && CLOCK_MULTIPLIER_SETTING == 2'h1
        && TX_CLOCK_DIVIDE_FACTOR == 2'h0 && $rose(TX_INPUT_CLOCK) |-> TX_INPUT_CLOCK[*2] ##1 !TX_INPUT_CLOCK)
        else $error("tx clock high phase not 2");
    mode_hold_a: assert property (run_q == 3'h7 |-> $stable(ALT_MODE)) else $error("mode moved");
    mux_b_a: assert property (steady && RX_MUX |-> RX_B_OUT == 12'h000) else $error("bus b busy in mux");
    dac_b_a: assert property (steady && !TX_DUAL_CHANNEL |-> $stable(DAC_B_DATA)) else $error("dac b moved");
endmodule
bind cdct_timing cdct_timing_monitor cdct_timing_monitor_inst (.CLK(CLK), .RSTN(RSTN),
    .CLOCK_MULTIPLIER_SETTING(CLOCK_MULTIPLIER_SETTING), .MULT_SETTING_VALID(MULT_SETTING_VALID),
    .SAMPLE_CLOCK_HALVE(SAMPLE_CLOCK_HALVE), .OUT_CLOCK_RATE_SELECT(OUT_CLOCK_RATE_SELECT),
    .RX_CLOCK_INVERT(RX_CLOCK_INVERT), .RX_MUX(RX_MUX), .TX_CLOCK_DIVIDE_FACTOR(TX_CLOCK_DIVIDE_FACTOR),
    .TX_DUAL_CHANNEL(TX_DUAL_CHANNEL), .ALT_MODE(ALT_MODE), .SAMPLE_STROBE(SAMPLE_STROBE),
    .RX_OUTPUT_CLOCK(RX_OUTPUT_CLOCK), .TX_INPUT_CLOCK(TX_INPUT_CLOCK), .RX_B_OUT(RX_B_OUT),
    .DAC_B_DATA(DAC_B_DATA));
`default_nettype wire

/* File: cdct_timing_test.sv */
/*
 * Self-checking bench for cdct_timing with the baseband model.
 * Assumes CLK of 4 ns and outputs settled 1 ns after the edge.
 */
`default_nettype none
module cdct_timing_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rstn = 1'b0, strap = 1'b1, msv = 1'b0, halve = 1'b0, sel = 1'b1, inv = 1'b0;
    logic        dec = 1'b0, mux = 1'b0, rpol = 1'b0, trt = 1'b0, fe = 1'b0, de = 1'b0, dual = 1'b0;
    logic        tpol = 1'b0, swap = 1'b0, men = 1'b0, ramp = 1'b0, tx_mark;
    logic [1:0]  mult = 2'h0, div = 2'h0;
    logic [11:0] adc_a = 12'h000, adc_b = 12'h000, rxa, rxb;
    logic [13:0] wa = 14'h0000, wb = 14'h0000, tx_data, daca, dacb;
    logic        alt, ss, rxc, txc, rmk, dval;
    int          miscompares = 0, tests_run = 0;
    cdct_timing cdct_timing_inst (.CLK(clk), .RSTN(rstn), .TIMING_MODE_STRAP(strap),
        .CLOCK_MULTIPLIER_SETTING(mult), .MULT_SETTING_VALID(msv), .SAMPLE_CLOCK_HALVE(halve),
        .OUT_CLOCK_RATE_SELECT(sel), .RX_CLOCK_INVERT(inv), .RX_RETIME_SELECT(1'b0), .RX_DECIMATE(dec),
        .RX_MUX(mux), .RX_MARKER_POLARITY(rpol), .ADC_A_DATA(adc_a), .ADC_B_DATA(adc_b),
        .TX_CLOCK_DIVIDE_FACTOR(div), .TX_RETIME_SELECT(trt), .TX_FALLING_EDGE_SELECT(fe),
        .TX_DUAL_EDGE_SELECT(de), .TX_DUAL_CHANNEL(dual), .TX_MARKER_POLARITY(tpol), .COMPLEX_ORDER_SWAP(swap),
        .TX_DATA(tx_data), .TX_CHANNEL_MARKER(tx_mark), .ALT_MODE(alt), .SAMPLE_STROBE(ss),
        .RX_OUTPUT_CLOCK(rxc), .TX_INPUT_CLOCK(txc), .RX_A_OUT(rxa), .RX_B_OUT(rxb),
        .RX_CHANNEL_MARKER(rmk), .DAC_A_DATA(daca), .DAC_B_DATA(dacb), .DAC_VALID(dval));
    cdct_asic_model cdct_asic_model_inst (.clk(clk), .rstn(rstn), .en(men), .tx_clk(txc), .dual(dual),
        .pol(tpol), .word_a(wa), .word_b(wb), .tx_data(tx_data), .tx_mark(tx_mark));
    ////////////////////////////////////////
    task wrap_up;
        $display("checks %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask
    // Longest period is 64 cycles, so this outlasts any pending ratio change
    task settle;
        repeat (140) @(posedge clk);
    endtask
    // Counts rises of a pulse or clock, or changes of bus A
    task count(input int s, input int n, output int c);
        logic [4:0]  p;
        logic [4:0]  v;
        logic [11:0] a;
        c = 0;
        @(posedge clk);
        #1;
        a = rxa;
        p = {1'b0, dval, txc, rxc, ss};
        repeat (n) begin
            @(posedge clk);
            #1;
            v = {rxa !== a, dval, txc, rxc, ss};
            a = rxa;
            if (v[s] && (s == 4 || !p[s]))
                c++;
            p = v;
        end
    endtask
    ////////////////////////////////////////
    task t_mode;
        repeat (6) @(posedge clk);
        #1;
        chk(alt, 1'b1);
        strap <= 1'b0;
        repeat (20) @(posedge clk);
        #1;
        chk(alt, 1'b1);
    endtask
    task t_sample;
        int c;
        int m;
        for (int i = 0; i < 12; i++) begin
            m = (i > 7 || i % 4 == 3) ? 2 : i % 4;
            @(posedge clk);
            mult <= i[1:0];
            halve <= i[2];
            msv <= !i[3];
            settle;
            count(0, 128, c);
            chk(c, 128 >> (3 - m + i[2]));
        end
    endtask
    task t_rxclk;
        int c;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            sel <= i[0];
            inv <= i[1];
            settle;
            count(1, 128, c);
            chk(c, i[0] ? 16 : 8);
        end
    endtask
    task t_rxdata;
        int c;
        int na;
        int nb;
        @(posedge clk);
        mult <= 2'h0;
        msv <= 1'b1;
        halve <= 1'b0;
        sel <= 1'b1;
        inv <= 1'b0;
        ramp <= 1'b1;
        for (int d = 0; d < 2; d++) begin
            @(posedge clk);
            dec <= d[0];
            settle;
            count(4, 256, c);
            chk(c, 32 >> d);
        end
        @(posedge clk);
        ramp <= 1'b0;
        dec <= 1'b0;
        adc_a <= 12'h5A3;
        adc_b <= 12'hC3C;
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            rpol <= i[0];
            mux <= 1'b1;
            settle;
            na = 0;
            nb = 0;
            repeat (64) begin
                @(posedge clk);
                #1;
                na += rxa === 12'h5A3;
                nb += rxa === 12'hC3C;
                if (rxa === 12'h5A3 || rxa === 12'hC3C)
                    chk(rmk, (rxa === 12'h5A3) ^ rpol);
            end
            chk(na > 0 && nb > 0, 1);
            mux <= 1'b0;
            settle;
            chk({rxa, rxb}, 24'h5A3C3C);
            chk(rmk, !rpol);
        end
    endtask
    task t_txclk;
        int c;
        int m;
        int d;
        for (int i = 0; i < 18; i++) begin
            m = i % 3;
            d = (i / 3) % 3;
            @(posedge clk);
            msv <= 1'b1;
            mult <= m[1:0];
            div <= d[1:0];
            halve <= i > 8;
            settle;
            count(2, 128, c);
            chk(c, 128 >> (3 + d - m));
        end
    endtask
    task t_txdata;
        int c;
        @(posedge clk);
        mult <= 2'h0;
        div <= 2'h1;
        halve <= 1'b0;
        wa <= 14'h2A5C;
        wb <= 14'h15A3;
        men <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            fe <= i == 1;
            de <= i == 2;
            trt <= i == 3;
            dual <= i > 3;
            tpol <= i[0];
            swap <= i[1];
            settle;
            count(3, 128, c);
            chk(c, (i == 2 || i == 3) ? 16 : (i > 3) ? 4 : 8);
            chk(daca, (i > 5) ? 14'h15A3 : 14'h2A5C);
            if (i > 3)
                chk(dacb, (i > 5) ? 14'h2A5C : 14'h15A3);
        end
    endtask
    task t_restrap;
        @(posedge clk);
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        chk(alt, 1'b0);
    endtask
    ////////////////////////////////////////
    always @(posedge clk)
        if (ramp)
            adc_a <= adc_a + 12'h001;
    initial begin
        forever #2 clk = ~clk;
    end
    // Whole run is near 51 us; the margin covers a slow divider
    initial begin
        #200000;
        miscompares++;
        wrap_up;
    end
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        t_mode;
        t_sample;
        t_rxclk;
        t_rxdata;
        t_txclk;
        t_txdata;
        t_restrap;
        wrap_up;
    end
endmodule
`default_nettype wire
